// File: line_ctl_pkg.sv
// Constants for the line control and line status block.
package line_ctl_pkg;
  // ----------------------------------------------------------------
  // Register selects (A2..A0)
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_DATA = 3'h0;
  localparam logic [2:0] SEL_IER = 3'h1;
  localparam logic [2:0] SEL_IIR = 3'h2;
  localparam logic [2:0] SEL_LFC = 3'h3;
  localparam logic [2:0] SEL_LCS = 3'h5;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LFC_STOP = 2;
  localparam int LFC_PAR_ON = 3;
  localparam int LFC_EVEN = 4;
  localparam int LFC_STICK = 5;
  localparam int LFC_BREAK = 6;
  localparam int LFC_DIV = 7;
  localparam int IER_HOLDING_EMPTY_FLAG = 1;
  localparam int IER_RLS = 2;
  // ----------------------------------------------------------------
  // Reset values and identification codes
  // ----------------------------------------------------------------
  localparam logic [7:0] LFC_RESET = 8'h00;
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [7:0] IIR_NONE = 8'h01;
  localparam logic [7:0] IIR_RLS = 8'h06;
  localparam logic [7:0] IIR_HOLDING_EMPTY_FLAG = 8'h02;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OVERSAMPLE = 16;
  localparam int MID_BIT = 8;
  localparam int HALF_STOP = 8;
  localparam int TX_DIV_RESET = 16;
endpackage

// File: sync2.sv
// Two-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Level in and out
  input wire logic d,
  output logic q
);
  logic meta_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: uart_line_control_status.sv
// Line format control, line status and serial engine of the transceiver.
// How it works
// - Two length bits give 5, 6, 7 or 8 data bits.
// - Stop select low sends one stop bit.
// - Stop select high sends 1.5 stops for 5 bits, else two.
// - Receiver checks both stop bits when two are programmed.
// - Parity enable inserts parity after data and checks it on receive.
// - Parity sense low is odd parity, high is even.
// - Stick parity sends and checks the inverse of the sense bit.
// - Break bit forces serial output low; transmitter keeps running.
// - Divisor access bit high diverts offsets 0 and 1 from data and enables.
// - Error flags set during stop bits; clean characters never clear them.
// - Overrun set when buffer is overwritten before the host read it.
// - Parity error set on parity mismatch.
// - Framing error set when the stop bit samples low.
// - Break flag set when input stays low a whole character.
// - Status read clears bits 1 to 4 only.
// - Data ready set on buffer load, cleared by buffer read.
// - Errors raise the top interrupt when enable bit 2 is set.
// - Holding empty set on move to shifter, cleared by host write.
// - Holding empty interrupt with enable bit 1; ident read drops it unless a line status interrupt is pending.
// - All-empty set when both are empty, clear until character leaves.
// - Status bit 7 reads zero.
// - Data goes least significant bit first, right-justified.
// - Receiver runs from a sixteen-times bit-rate clock enable.
`timescale 1ns/1ps
`default_nettype none
module uart_line_control_status
  import line_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [2:0] reg_sel,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // Baud enables
  input wire logic rclk_en,
  // Serial line
  input wire logic serial_in,
  output logic serial_out,
  // Interrupt and divisor access bit
  output logic irq_out,
  output logic divisor_access_bit
);
  import line_ctl_pkg::*;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [7:0] lfc_q, ier_q, rbuf_q, thr_q;
  logic rx_data_ready, overrun_q, parity_error_flag, framing_error_flag;
  logic break_seen_flag, holding_empty_flag, tx_all_empty_flag;
  logic holding_empty_flag_irq_q;
  logic sin_s;
  logic [1:0] len_code;
  logic [3:0] nbits;
  logic wr_data_reg, rd_data_reg, rd_status, rd_ident;
  logic rls_pend;

  sync2 u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(serial_in),
    .q(sin_s)
  );

  assign len_code = lfc_q[1:0];
  assign nbits = 4'(5 + len_code);
  assign divisor_access_bit = lfc_q[LFC_DIV];
  assign wr_data_reg = wr_stb && reg_sel == SEL_DATA && !lfc_q[LFC_DIV];
  assign rd_data_reg = rd_stb && reg_sel == SEL_DATA && !lfc_q[LFC_DIV];
  assign rd_status = rd_stb && reg_sel == SEL_LCS;
  assign rd_ident = rd_stb && reg_sel == SEL_IIR;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      lfc_q <= LFC_RESET;
    end else if (wr_stb && reg_sel == SEL_LFC) begin
      lfc_q <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ier_q <= IER_RESET;
    end else if (wr_stb && reg_sel == SEL_IER && !lfc_q[LFC_DIV]) begin
      ier_q <= wr_data;
    end
  end

  // Parity value for a data byte, masked to the programmed length.
  function automatic logic par_bit(input logic [7:0] d, input logic [3:0] n,
                                   input logic [7:0] lfc);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < n) p = p ^ d[i];
    end
    if (lfc[LFC_STICK]) par_bit = !lfc[LFC_EVEN];
    else par_bit = lfc[LFC_EVEN] ? p : !p;
  endfunction

  // ------------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  tx_state_t tx_st_q;
  logic [7:0] transmit_shifter;
  logic [3:0] tx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [5:0] tx_stop_q;
  logic tx_line_q;
  logic tx_busy;
  logic load_shifter;

  assign tx_busy = tx_st_q != TX_IDLE;
  assign load_shifter = !tx_busy && !holding_empty_flag;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_st_q <= TX_IDLE;
      transmit_shifter <= 8'h00;
      tx_cnt_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_stop_q <= 6'h00;
      tx_line_q <= 1'b1;
    end else if (load_shifter) begin
      transmit_shifter <= thr_q;
      tx_st_q <= TX_START;
      tx_cnt_q <= 4'h0;
      tx_line_q <= 1'b0;
    end else if (tx_busy && rclk_en) begin
      tx_cnt_q <= tx_cnt_q + 4'h1;
      if (tx_st_q == TX_STOP) begin
        tx_stop_q <= tx_stop_q - 6'h01;
        if (tx_stop_q == 6'h01) tx_st_q <= TX_IDLE;
      end else if (tx_cnt_q == 4'(OVERSAMPLE - 1)) begin
        unique case (tx_st_q)
          TX_START: begin
            tx_st_q <= TX_DATA;
            tx_bit_q <= 3'h0;
            tx_line_q <= transmit_shifter[0];
          end
          TX_DATA: begin
            if (4'(tx_bit_q) == nbits - 4'h1) begin
              if (lfc_q[LFC_PAR_ON]) begin
                tx_st_q <= TX_PAR;
                tx_line_q <= par_bit(transmit_shifter, nbits, lfc_q);
              end else begin
                tx_st_q <= TX_STOP;
                tx_line_q <= 1'b1;
                tx_stop_q <= stop_len();
              end
            end else begin
              tx_bit_q <= tx_bit_q + 3'h1;
              tx_line_q <= transmit_shifter[tx_bit_q + 3'h1];
            end
          end
          TX_PAR: begin
            tx_st_q <= TX_STOP;
            tx_line_q <= 1'b1;
            tx_stop_q <= stop_len();
          end
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end

  // Stop time in enable ticks: 16, 24 for 1.5 stops, or 32.
  function automatic logic [5:0] stop_len();
    if (!lfc_q[LFC_STOP]) stop_len = 6'(OVERSAMPLE);
    else if (len_code == 2'b00) stop_len = 6'(OVERSAMPLE + HALF_STOP);
    else stop_len = 6'(2 * OVERSAMPLE);
  endfunction

  // Break gates only the pin; the engine keeps timing characters.
  assign serial_out = tx_line_q && !lfc_q[LFC_BREAK];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      thr_q <= 8'h00;
      holding_empty_flag <= 1'b1;
    end else if (wr_data_reg) begin
      thr_q <= wr_data;
      holding_empty_flag <= 1'b0;
    end else if (load_shifter) begin
      holding_empty_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_all_empty_flag <= 1'b1;
    end else if (wr_data_reg) begin
      tx_all_empty_flag <= 1'b0;
    end else begin
      tx_all_empty_flag <= holding_empty_flag && !tx_busy;
    end
  end

  // ------------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2}
    rx_state_t;
  rx_state_t rx_st_q;
  logic [7:0] rx_shift_q;
  logic [3:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic rx_par_bad_q, rx_stop_bad_q, rx_any_one_q, sin_prev_q;
  logic rx_done;
  logic rx_done_par, rx_done_frm, rx_done_brk;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sin_prev_q <= 1'b1;
    end else if (rclk_en) begin
      sin_prev_q <= sin_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_st_q <= RX_IDLE;
      rx_shift_q <= 8'h00;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_par_bad_q <= 1'b0;
      rx_stop_bad_q <= 1'b0;
      rx_any_one_q <= 1'b0;
    end else if (rclk_en) begin
      rx_cnt_q <= rx_cnt_q + 4'h1;
      unique case (rx_st_q)
        RX_IDLE: begin
          if (sin_prev_q && !sin_s) begin
            rx_st_q <= RX_START;
            rx_cnt_q <= 4'h1;
            rx_shift_q <= 8'h00;
            rx_par_bad_q <= 1'b0;
            rx_stop_bad_q <= 1'b0;
            rx_any_one_q <= 1'b0;
          end
        end
        RX_START: begin
          if (rx_cnt_q == 4'(MID_BIT - 1)) begin
            if (sin_s) rx_st_q <= RX_IDLE;
            else begin
              rx_st_q <= RX_DATA;
              rx_cnt_q <= 4'h0;
              rx_bit_q <= 3'h0;
            end
          end
        end
        RX_DATA: begin
          if (rx_cnt_q == 4'(OVERSAMPLE - 1)) begin
            rx_shift_q[rx_bit_q] <= sin_s;
            rx_any_one_q <= rx_any_one_q | sin_s;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (4'(rx_bit_q) == nbits - 4'h1)
              rx_st_q <= lfc_q[LFC_PAR_ON] ? RX_PAR : RX_STOP1;
          end
        end
        RX_PAR: begin
          if (rx_cnt_q == 4'(OVERSAMPLE - 1)) begin
            rx_par_bad_q <= sin_s != par_bit(rx_shift_q, nbits, lfc_q);
            rx_any_one_q <= rx_any_one_q | sin_s;
            rx_st_q <= RX_STOP1;
          end
        end
        RX_STOP1: begin
          if (rx_cnt_q == 4'(OVERSAMPLE - 1)) begin
            rx_stop_bad_q <= !sin_s;
            rx_any_one_q <= rx_any_one_q | sin_s;
            rx_st_q <= (lfc_q[LFC_STOP] && len_code != 2'b00) ? RX_STOP2 : RX_IDLE;
          end
        end
        RX_STOP2: begin
          if (rx_cnt_q == 4'(OVERSAMPLE - 1)) begin
            rx_stop_bad_q <= rx_stop_bad_q | !sin_s;
            rx_any_one_q <= rx_any_one_q | sin_s;
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Completion is seen at the last stop sample; error terms include that sample.
  assign rx_done = rclk_en && rx_cnt_q == 4'(OVERSAMPLE - 1) &&
                   ((rx_st_q == RX_STOP1 && !(lfc_q[LFC_STOP] && len_code != 2'b00)) ||
                    rx_st_q == RX_STOP2);
  assign rx_done_frm = (rx_stop_bad_q && rx_st_q == RX_STOP2) || !sin_s;
  assign rx_done_par = rx_par_bad_q;
  assign rx_done_brk = !rx_any_one_q && !sin_s;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rbuf_q <= 8'h00;
    end else if (rx_done) begin
      rbuf_q <= rx_shift_q;
    end
  end

  // Flags: a setting event wins over a clearing read in the same cycle.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_data_ready <= 1'b0;
    end else if (rx_done) begin
      rx_data_ready <= 1'b1;
    end else if (rd_data_reg) begin
      rx_data_ready <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      overrun_q <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      break_seen_flag <= 1'b0;
    end else begin
      overrun_q <= (rx_done && rx_data_ready && !rd_data_reg) ||
                   (overrun_q && !rd_status);
      parity_error_flag <= (rx_done && rx_done_par) ||
                           (parity_error_flag && !rd_status);
      framing_error_flag <= (rx_done && rx_done_frm) ||
                            (framing_error_flag && !rd_status);
      break_seen_flag <= (rx_done && rx_done_brk) ||
                         (break_seen_flag && !rd_status);
    end
  end

  // ------------------------------------------------------------------
  // Interrupts and read data
  // ------------------------------------------------------------------
  assign rls_pend = ier_q[IER_RLS] && (overrun_q || parity_error_flag ||
                    framing_error_flag || break_seen_flag);

  logic holding_empty_flag_prev_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      holding_empty_flag_irq_q <= 1'b0;
      holding_empty_flag_prev_q <= 1'b1;
    end else begin
      holding_empty_flag_prev_q <= holding_empty_flag;
      if ((holding_empty_flag && !holding_empty_flag_prev_q) ||
          (wr_data[IER_HOLDING_EMPTY_FLAG] && wr_stb && reg_sel == SEL_IER && !lfc_q[LFC_DIV]))
        holding_empty_flag_irq_q <= 1'b1;
      else if (!holding_empty_flag || (rd_ident && !rls_pend))
        holding_empty_flag_irq_q <= 1'b0;
    end
  end

  assign irq_out = rls_pend || (ier_q[IER_HOLDING_EMPTY_FLAG] && holding_empty_flag_irq_q);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else if (rd_stb) begin
      unique case (reg_sel)
        SEL_DATA: rd_data <= lfc_q[LFC_DIV] ? 8'h00 : rbuf_q;
        SEL_IER: rd_data <= lfc_q[LFC_DIV] ? 8'h00 : ier_q;
        SEL_IIR: rd_data <= rls_pend ? IIR_RLS :
                            (ier_q[IER_HOLDING_EMPTY_FLAG] && holding_empty_flag_irq_q) ? IIR_HOLDING_EMPTY_FLAG : IIR_NONE;
        SEL_LFC: rd_data <= lfc_q;
        SEL_LCS: rd_data <= {1'b0, tx_all_empty_flag, holding_empty_flag,
                             break_seen_flag, framing_error_flag,
                             parity_error_flag, overrun_q, rx_data_ready};
        default: rd_data <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  break_out_a: assert property (@(posedge clk) disable iff (!rstn)
    lfc_q[LFC_BREAK] |-> !serial_out) else $error("break not forcing low");
  status_clr_a: assert property (@(posedge clk) disable iff (!rstn)
    rd_status && !rx_done |=> !overrun_q && !framing_error_flag)
    else $error("status read left flags");
  ready_set_a: assert property (@(posedge clk) disable iff (!rstn)
    rx_done |=> rx_data_ready) else $error("ready not set");
  overrun_set_a: assert property (@(posedge clk) disable iff (!rstn)
    rx_done && rx_data_ready && !rd_data_reg |=> overrun_q)
    else $error("overrun missed");
  holding_empty_flag_clr_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_data_reg |=> !holding_empty_flag && !tx_all_empty_flag)
    else $error("write left empty flags");
  tx_all_empty_flag_busy_a: assert property (@(posedge clk) disable iff (!rstn)
    tx_busy |-> ##1 !tx_all_empty_flag) else $error("all-empty while busy");
  rls_irq_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(parity_error_flag) && ier_q[IER_RLS] |-> irq_out)
    else $error("line status irq missing");
  bit7_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(rd_status) |-> !rd_data[7]) else $error("status bit 7 set");
  start_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    load_shifter |=> !tx_line_q) else $error("no start bit");
  tx_load_c: cover property (@(posedge clk) disable iff (!rstn) load_shifter);
  rx_done_c: cover property (@(posedge clk) disable iff (!rstn) rx_done);
  brk_c: cover property (@(posedge clk) disable iff (!rstn) rx_done && rx_done_brk);
endmodule
`default_nettype wire

// File: serial_peer.sv
// Far-side serial terminal model: sends frames and decodes the block's output.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  // Clock and bit-rate enable
  input wire logic clk,
  input wire logic rclk_en,
  // Format in force and serial line
  input wire logic [7:0] fmt,
  input wire logic serial_out,
  output logic serial_in
);
  logic [9:0] got_q[$];
  logic [9:0] w;
  int n;
  initial serial_in = 1'b1;
  task automatic tick(input int c);
    repeat (c) @(posedge clk iff rclk_en);
  endtask
  // ----------------------------------------------------------------
  // Sender
  // ----------------------------------------------------------------
  // The caller builds the frame; the line returns to mark after it.
  // Mark is held two ticks so that a frame sent right after one with a low
  // stop bit still starts with a falling edge the receiver can see.
  task automatic send_bits(input logic [15:0] b, input int c);
    for (int i = 0; i < c; i++) begin
      #1 serial_in = b[i];
      tick(16);
    end
    #1 serial_in = 1'b1;
    tick(2);
  endtask
  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // Keeps data and parity in the low bits and the stop level in bit 9.
  always begin
    @(negedge serial_out);
    n = 5 + fmt[1:0] + fmt[3];
    w = 10'h000;
    tick(8);
    for (int i = 0; i < n; i++) begin
      tick(16);
      w[i] = serial_out;
    end
    tick(16);
    w[9] = serial_out;
    if (fmt[2] && fmt[1:0] != 2'h0) begin
      tick(16);
      w[9] = w[9] & serial_out;
    end
    got_q.push_back(w);
  end
endmodule
`default_nettype wire

// File: uart_line_control_status_tb.sv
// Self-checking bench for the line control and line status block.
`timescale 1ns/1ps
`default_nettype none
module uart_line_control_status_tb;
  import line_ctl_pkg::*;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] reg_sel = 3'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic rclk_en = 1'b0;
  logic [7:0] rd_data;
  logic serial_in;
  logic serial_out;
  logic irq_out;
  logic divisor_access_bit;
  logic [7:0] fmt = 8'h00;
  logic [7:0] ier_v = 8'h00;
  logic [7:0] s = 8'h00;
  logic [1:0] tk = 2'h0;
  int tick_cnt = 0;
  int cyc = 0;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 32'h8e2c;
  uart_line_control_status dut (.clk(clk), .rstn(rstn), .reg_sel(reg_sel),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data),
    .rclk_en(rclk_en), .serial_in(serial_in), .serial_out(serial_out),
    .irq_out(irq_out), .divisor_access_bit(divisor_access_bit));
  serial_peer peer (.clk(clk), .rclk_en(rclk_en), .fmt(fmt),
    .serial_out(serial_out), .serial_in(serial_in));
  initial begin
    forever #5 clk = ~clk;
  end
  // One enable in four clocks keeps a character under a thousand cycles.
  always @(posedge clk) begin
    #1;
    tk = tk + 2'h1;
    rclk_en = (tk == 2'h3);
    if (rclk_en) tick_cnt++;
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Register access and reference helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 reg_sel = a;
    wr_data = v;
    wr_stb = 1'b1;
    if (a == SEL_LFC) fmt = v;
    if (a == SEL_IER && !fmt[LFC_DIV]) ier_v = v;
    @(posedge clk);
    #1 wr_stb = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    #1 reg_sel = a;
    rd_stb = 1'b1;
    @(posedge clk);
    #1 rd_stb = 1'b0;
    v = rd_data;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask
  function automatic logic [7:0] msk(input logic [7:0] f);
    return 8'hff >> (3 - f[1:0]);
  endfunction
  function automatic logic par_of(input logic [7:0] v, input logic [7:0] f);
    if (f[LFC_STICK]) return ~f[LFC_EVEN];
    return f[LFC_EVEN] ? ^(v & msk(f)) : ~^(v & msk(f));
  endfunction
  // ----------------------------------------------------------------
  // Scenario tasks
  // ----------------------------------------------------------------
  task automatic tx_case(input logic [7:0] v);
    int t0;
    int len;
    int want;
    logic [9:0] w;
    logic [9:0] got;
    len = 5 + fmt[1:0];
    want = (1 + len + fmt[LFC_PAR_ON]) * 16;
    want += !fmt[LFC_STOP] ? 16 : (len == 5 ? 24 : 32);
    w = 10'h200 | (v & msk(fmt));
    if (fmt[LFC_PAR_ON]) w[len] = par_of(v, fmt);
    wr(SEL_DATA, v);
    t0 = tick_cnt;
    rd(SEL_LCS, s);
    `CHK(s[6], 1'b0)
    for (int k = 0; k < 2000 && !s[6]; k++) rd(SEL_LCS, s);
    `CHK((tick_cnt - t0 - want) inside {[-2:2]}, 1'b1)
    got = peer.got_q.size() > 0 ? peer.got_q.pop_front() : 10'h000;
    `CHK(got, w)
  endtask
  // The short wait covers the input synchroniser and the buffer load.
  task automatic chk_rx(input logic [7:0] es, input logic [7:0] ed);
    logic err;
    err = (es[4:1] != 4'h0);
    repeat (4) @(posedge clk);
    `CHK(irq_out, ier_v[IER_RLS] & err)
    rdc(SEL_IIR, (ier_v[IER_RLS] & err) ? IIR_RLS : IIR_NONE);
    rdc(SEL_LCS, es);
    rdc(SEL_LCS, es & 8'he1);
    `CHK(irq_out, 1'b0)
    rdc(SEL_DATA, ed);
    rdc(SEL_LCS, 8'h60);
  endtask
  task automatic rx_case(input logic [7:0] v, input logic bad, input logic stp);
    logic [15:0] b;
    int n;
    int ns;
    n = 6 + fmt[1:0];
    ns = (fmt[LFC_STOP] && fmt[1:0] != 2'h0) ? 2 : 1;
    b = {7'h00, v & msk(fmt), 1'b0};
    if (fmt[LFC_PAR_ON]) begin
      b[n] = par_of(v, fmt) ^ bad;
      n++;
    end
    for (int k = 0; k < ns; k++) b[n + k] = (k == ns - 1) ? stp : 1'b1;
    peer.send_bits(b, n + ns);
    chk_rx(8'h61 | {4'h0, !stp, bad & fmt[LFC_PAR_ON], 2'h0}, v & msk(fmt));
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] f;
    logic [7:0] d;
    logic [7:0] d1;
    logic lo;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    rdc(SEL_LCS, 8'h60);
    rdc(SEL_LFC, LFC_RESET);
    rdc(3'h7, 8'h00);
    `CHK({serial_out, irq_out}, 2'b10)
    $display("test reset done");
    for (int i = 0; i < 20; i++) begin
      f = {2'b00, (i < 16) ? i[3:2] : 2'b00, i < 16, i[2] ^ i[0], i[1:0]};
      wr(SEL_LFC, f);
      rdc(SEL_LFC, f);
      wr(SEL_IER, {5'h00, i[0], 2'h0});
      d = 8'($random(seed));
      tx_case(d);
      d = 8'($random(seed)) | 8'h01;
      rx_case(d, i[0], i[1] | ~i[3]);
    end
    $display("test formats done");
    wr(SEL_LFC, 8'h03);
    d = 8'($random(seed)) | 8'h01;
    d1 = 8'($random(seed));
    peer.send_bits({7'h7e, d, 1'b0}, 10);
    peer.send_bits({7'h7f, d1, 1'b0}, 10);
    chk_rx(8'h6b, d1);
    peer.send_bits(16'h0000, 12);
    chk_rx(8'h79, 8'h00);
    $display("test errors done");
    rdc(SEL_IIR, IIR_NONE);
    wr(SEL_IER, 8'h02);
    `CHK(irq_out, 1'b1)
    rdc(SEL_IIR, IIR_HOLDING_EMPTY_FLAG);
    `CHK(irq_out, 1'b0)
    tx_case(8'h5a);
    `CHK(irq_out, 1'b1)
    wr(SEL_IER, 8'h00);
    $display("test holding irq done");
    wr(SEL_LFC, 8'h83);
    `CHK(divisor_access_bit, 1'b1)
    wr(SEL_DATA, 8'h55);
    rdc(SEL_DATA, 8'h00);
    rdc(SEL_LCS, 8'h60);
    wr(SEL_LFC, 8'h03);
    `CHK(divisor_access_bit, 1'b0)
    $display("test divisor done");
    wr(SEL_DATA, 8'h00);
    s = 8'h00;
    for (int k = 0; k < 2000 && !s[5]; k++) rd(SEL_LCS, s);
    wr(SEL_LFC, 8'h43);
    lo = 1'b1;
    s = 8'h00;
    for (int k = 0; k < 2000 && !s[6]; k++) begin
      rd(SEL_LCS, s);
      lo &= (serial_out === 1'b0);
    end
    `CHK(lo, 1'b1)
    `CHK(s[6], 1'b1)
    wr(SEL_LFC, 8'h03);
    `CHK(serial_out, 1'b1)
    peer.got_q.delete();
    $display("test break done");
    give_verdict();
  end
endmodule
`default_nettype wire
